// ===== core/pvi3d_src.sv
// Video source end: AXI4-Lite controlled timing generator driving the link.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module pvi3d_src (
	// System clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// AXI4-Lite write channels.
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels.
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Parallel video link.
	pvi3d_link_if.src        link
);
	logic [31:0] ctrl;
	logic [31:0] size;
	logic [31:0] base;
	logic [15:0] frame_cnt;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        aw_have;
	logic        w_have;

	// Byte-lane merge of a write into a register.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Handshake terms.
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire do_wr = aw_have & w_have & ~s_axi_bvalid;
	wire wr_ok = (aw_addr == pvi3d_pkg::REG_CTRL) || (aw_addr == pvi3d_pkg::REG_SIZE) ||
		(aw_addr == pvi3d_pkg::REG_BASE);
	wire rd_ok = (s_axi_araddr == pvi3d_pkg::REG_CTRL) || (s_axi_araddr == pvi3d_pkg::REG_SIZE) ||
		(s_axi_araddr == pvi3d_pkg::REG_STATUS) || (s_axi_araddr == pvi3d_pkg::REG_BASE);
	wire [31:0] rd_mux =
		(s_axi_araddr == pvi3d_pkg::REG_CTRL)   ? ctrl :
		(s_axi_araddr == pvi3d_pkg::REG_SIZE)   ? size :
		(s_axi_araddr == pvi3d_pkg::REG_STATUS) ? {15'h0000, link.eye_select_in, frame_cnt} :
		(s_axi_araddr == pvi3d_pkg::REG_BASE)   ? base : 32'h0000_0000;

	// Write address and data are held until both are in, then applied.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= pvi3d_pkg::RESP_OKAY;
			ctrl          <= pvi3d_pkg::CTRL_RST;
			size          <= pvi3d_pkg::SIZE_RST;
			base          <= pvi3d_pkg::BASE_RST;
		end else begin
			if (aw_take) begin
				aw_addr <= s_axi_awaddr;
				aw_have <= 1'b1;
			end else if (do_wr) begin
				aw_have <= 1'b0;
			end
			if (w_take) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_have <= 1'b1;
			end else if (do_wr) begin
				w_have <= 1'b0;
			end
			s_axi_awready <= ~(aw_have | aw_take) | do_wr;
			s_axi_wready  <= ~(w_have | w_take) | do_wr;
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? pvi3d_pkg::RESP_OKAY : pvi3d_pkg::RESP_SLVERR;
				if (aw_addr == pvi3d_pkg::REG_CTRL) begin
					ctrl <= merge(ctrl, w_data, w_strb);
				end
				if (aw_addr == pvi3d_pkg::REG_SIZE) begin
					size <= merge(size, w_data, w_strb);
				end
				if (aw_addr == pvi3d_pkg::REG_BASE) begin
					base <= merge(base, w_data, w_strb);
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read answers one cycle after the address is taken.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= pvi3d_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= ~ar_take & (~s_axi_rvalid | s_axi_rready);
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_ok ? pvi3d_pkg::RESP_OKAY : pvi3d_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Video timing terms; the link changes on the falling pixel clock edge.
	logic [4:0]  div;
	logic [11:0] h;
	logic [11:0] v;
	wire        en = ctrl[pvi3d_pkg::CTRL_EN];
	wire        tick = div == 5'(pvi3d_pkg::PCLK_HALF_CYC - 1);
	wire        fall = tick & link.pclk;
	wire [11:0] hact = size[pvi3d_pkg::SIZE_H_LO +: 12];
	wire [11:0] vact = size[pvi3d_pkg::SIZE_V_LO +: 12];
	wire [11:0] hs_on = 12'(hact + pvi3d_pkg::H_FP);
	wire [11:0] hs_off = 12'(hs_on + pvi3d_pkg::H_SW);
	wire [11:0] h_last = 12'(hs_off + pvi3d_pkg::H_BP - 12'h001);
	wire [11:0] vs_on = 12'(vact + pvi3d_pkg::V_FP);
	wire [11:0] vs_off = 12'(vs_on + pvi3d_pkg::V_SW);
	wire [11:0] v_last = 12'(vs_off + pvi3d_pkg::V_BP - 12'h001);
	wire        active = (h < hact) && (v < vact);
	wire        blank_start = (v == vact) && (h == 12'h000);
	wire [23:0] pd = 24'(base[23:0] + {12'h000, h});
	wire [1:0]  fmt = ctrl[pvi3d_pkg::CTRL_FMT_LO +: 2];
	wire [23:0] word =
		(fmt == pvi3d_pkg::PVI3D_FMT18) ? {6'h00, pd[17:0]} :
		(fmt == pvi3d_pkg::PVI3D_FMT16) ? {8'h00, pd[15:0]} : pd;

	// Pixel clock divider runs free so the link clock never stops.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div       <= 5'h00;
			link.pclk <= 1'b0;
		end else if (tick) begin
			div       <= 5'h00;
			link.pclk <= ~link.pclk;
		end else begin
			div <= 5'(div + 5'h01);
		end
	end

	// Raster counters, syncs, eye order, mask and pixel data.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			h                      <= 12'h000;
			v                      <= 12'h000;
			frame_cnt              <= 16'h0000;
			link.vsync             <= 1'b0;
			link.hsync             <= 1'b0;
			link.pixel_valid_in    <= 1'b0;
			link.pixel_bus         <= 24'h000000;
			link.frame_update_mask <= 1'b0;
			link.eye_select_in     <= 1'b0;
		end else if (fall) begin
			if (!en) begin
				h <= 12'h000;
				v <= 12'h000;
			end else if (h == h_last) begin
				h <= 12'h000;
				v <= (v == v_last) ? 12'h000 : 12'(v + 12'h001);
			end else begin
				h <= 12'(h + 12'h001);
			end
			// Syncs run for as long as the source is enabled.
			link.vsync          <= en && (v >= vs_on) && (v < vs_off);
			link.hsync          <= en && (h >= hs_on) && (h < hs_off);
			link.pixel_valid_in <= en && active;
			link.pixel_bus      <= (en && active) ? word : 24'h000000;
			if (en && blank_start) begin
				frame_cnt              <= 16'(frame_cnt + 16'h0001);
				link.eye_select_in     <= ctrl[pvi3d_pkg::CTRL_3D] & ~link.eye_select_in;
				link.frame_update_mask <= ctrl[pvi3d_pkg::CTRL_MASK];
			end
		end
	end
endmodule
`default_nettype wire

// ===== pkg/pvi3d_pkg.sv
// Shared constants and types for the parallel video input link.
package pvi3d_pkg;

	// Pixel word formats on the parallel bus.
	typedef enum logic [1:0] {
		PVI3D_FMT24 = 2'b00,
		PVI3D_FMT18 = 2'b01,
		PVI3D_FMT16 = 2'b10
	} pvi3d_fmt_e;

	// System clock rate and the vertical sync watchdog time.
	localparam int unsigned CLK_MHZ        = 250;
	localparam int unsigned VS_TIMEOUT_US  = 50000;
	localparam int unsigned VS_TIMEOUT_CYC = VS_TIMEOUT_US * CLK_MHZ;

	// Pixel clock made by the source: half period in system clocks.
	localparam int unsigned PCLK_HALF_CYC  = 20;

	// Source register byte offsets.
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_SIZE   = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_BASE   = 4'hc;

	// Control field positions.
	localparam int unsigned CTRL_EN     = 0;
	localparam int unsigned CTRL_MASK   = 1;
	localparam int unsigned CTRL_3D     = 2;
	localparam int unsigned CTRL_FMT_LO = 4;

	// Size field positions.
	localparam int unsigned SIZE_H_LO = 0;
	localparam int unsigned SIZE_V_LO = 16;

	// Register values after reset.
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] SIZE_RST = 32'h0168_0280;
	localparam logic [31:0] BASE_RST = 32'h0000_0000;

	// Blanking intervals in pixel clocks and lines; short, so that a small frame passes quickly.
	localparam logic [11:0] H_FP = 12'h002;
	localparam logic [11:0] H_SW = 12'h002;
	localparam logic [11:0] H_BP = 12'h002;
	localparam logic [11:0] V_FP = 12'h001;
	localparam logic [11:0] V_SW = 12'h001;
	localparam logic [11:0] V_BP = 12'h002;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== pkg/pvi3d_link_if.sv
// Parallel video link between the source and the display controller input.
`timescale 1ns/100ps
`default_nettype none
interface pvi3d_link_if;
	logic        pclk;
	logic        vsync;
	logic        hsync;
	logic        pixel_valid_in;
	logic [23:0] pixel_bus;
	logic        frame_update_mask;
	logic        eye_select_in;

	// Source end drives every wire of the link.
	modport src (
		output pclk, vsync, hsync, pixel_valid_in, pixel_bus, frame_update_mask, eye_select_in
	);

	// Display controller end only receives.
	modport dev (
		input pclk, vsync, hsync, pixel_valid_in, pixel_bus, frame_update_mask, eye_select_in
	);
endinterface
`default_nettype wire

// ===== core/pvi3d_sync2.sv
// Two-flop synchroniser for levels entering a clock domain.
`timescale 1ns/100ps
`default_nettype none
module pvi3d_sync2 #(
	parameter int unsigned W = 1
) (
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Level in and synchronised level out.
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	logic [W-1:0] meta;

	// The first stage feeds only the second.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule
`default_nettype wire

// ===== core/pvi3d_dev.sv
// Display controller end: captures parallel video frames from the link.
// Function
// - Source sends 3D frames left, right alternately.
// - One eye per frame, frames split by vsync.
// - Eye select sampled once per frame.
// - One output frame per input frame.
// - Eye phase output drives glasses sync.
// - Source keeps vertical sync toggling always; pvi3d_src holds vsync low while CTRL_EN is clear.
// - Stalled vsync halts sequencer, LEDs off.
// - Sync active edges selectable separately.
// - Asserted mask blocks pixels, keeps image.
// - Masked frames hold image, no blanking.
// - Mask polarity is programmable.
// - Mask polarity defaults to active high.
// - Unused mask input is tied low.
// - Mask changes only in vertical blanking.
// - 24-bit formats: 8 bits per component.
// - 18-bit formats: 6 bits per component.
// - 4:2:2 words pair, chroma co-sited even.
// - No portrait rotation, landscape only.
`timescale 1ns/100ps
`default_nettype none
module pvi3d_dev #(
	parameter int unsigned VS_TIMEOUT_CYC = pvi3d_pkg::VS_TIMEOUT_CYC
) (
	// System clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Parallel video link.
	pvi3d_link_if.dev        link,
	// Static configuration.
	input  wire logic        vs_rise_i,
	input  wire logic        hs_rise_i,
	input  wire logic        mask_low_i,
	input  wire logic [1:0]  fmt_i,
	// Pixel stream, pixel clock domain.
	output var  logic [23:0] pix_o,
	output var  logic        pix_valid_o,
	output var  logic        frame_start_o,
	output var  logic        line_start_o,
	output var  logic        frame_hold_o,
	output var  logic        eye_phase_o,
	// Sequencer status, system clock domain.
	output var  logic        seq_run_o,
	output var  logic        led_en_o
);
	localparam logic [31:0] TIMEOUT = 32'(VS_TIMEOUT_CYC);

	// Configuration brought into the pixel clock domain.
	logic [4:0] cfg_q;
	pvi3d_sync2 #(
		.W(5)
	) u_cfg_sync (
		.clk_i (link.pclk),
		.rst_i (rst_i),
		.d_i   ({vs_rise_i, hs_rise_i, mask_low_i, fmt_i}),
		.q_o   (cfg_q)
	);

	// Pixel clock domain state.
	logic        vs_d;
	logic        hs_d;
	logic        mask_pol;
	logic        odd;
	logic        pend;
	logic [7:0]  y_hold;
	logic [7:0]  cb_hold;
	logic [23:0] stash;
	logic [1:0]  fmt;

	// Edge selection per sync and mask polarity.
	wire        vs_rise = cfg_q[4];
	wire        hs_rise = cfg_q[3];
	wire        vs_edge = vs_rise ? (link.vsync & ~vs_d) : (~link.vsync & vs_d);
	wire        hs_edge = hs_rise ? (link.hsync & ~hs_d) : (~link.hsync & hs_d);
	wire        mask_act = link.frame_update_mask ^ mask_pol;
	wire        take = link.pixel_valid_in & ~mask_act;
	wire        fmt16 = fmt == pvi3d_pkg::PVI3D_FMT16;
	wire [23:0] w = link.pixel_bus;

	// Six-bit components are widened by repeating their top bits.
	wire [23:0] p18 = {w[17:12], w[17:16], w[11:6], w[11:10], w[5:0], w[5:4]};
	wire [23:0] flat = (fmt == pvi3d_pkg::PVI3D_FMT18) ? p18 : w;
	wire [7:0]  luma = w[15:8];
	wire [7:0]  chroma = w[7:0];

	// Sync history, polarity and format follow the configuration.
	always_ff @(posedge link.pclk or posedge rst_i) begin
		if (rst_i) begin
			vs_d     <= 1'b0;
			hs_d     <= 1'b0;
			mask_pol <= 1'b0;
			fmt      <= 2'h0;
		end else begin
			vs_d     <= link.vsync;
			hs_d     <= link.hsync;
			mask_pol <= cfg_q[2];
			fmt      <= cfg_q[1:0];
		end
	end

	// Frame and line markers, eye latch and hold flag.
	always_ff @(posedge link.pclk or posedge rst_i) begin
		if (rst_i) begin
			frame_start_o <= 1'b0;
			line_start_o  <= 1'b0;
			frame_hold_o  <= 1'b0;
			eye_phase_o   <= 1'b0;
		end else begin
			frame_start_o <= vs_edge;
			line_start_o  <= hs_edge;
			frame_hold_o  <= mask_act;
			if (vs_edge) begin
				eye_phase_o <= link.eye_select_in;
			end
		end
	end

	// Even/odd word phase of 4:2:2 pairs, restarted each line.
	always_ff @(posedge link.pclk or posedge rst_i) begin
		if (rst_i) begin
			odd     <= 1'b0;
			y_hold  <= 8'h00;
			cb_hold <= 8'h00;
		end else if (hs_edge || vs_edge) begin
			odd <= 1'b0;
		end else if (take && fmt16) begin
			odd <= ~odd;
			if (!odd) begin
				y_hold  <= luma;
				cb_hold <= chroma;
			end
		end
	end

	// Pixel output; pixels leave in arrival order, never rotated.
	always_ff @(posedge link.pclk or posedge rst_i) begin
		if (rst_i) begin
			pix_o       <= 24'h000000;
			pix_valid_o <= 1'b0;
			pend        <= 1'b0;
			stash       <= 24'h000000;
		end else begin
			pix_valid_o <= 1'b0;
			pend        <= 1'b0;
			if (take && !fmt16) begin
				pix_o       <= flat;
				pix_valid_o <= 1'b1;
			end else if (take && fmt16 && odd) begin
				pix_o       <= {y_hold, cb_hold, chroma};
				pix_valid_o <= 1'b1;
				stash       <= {luma, cb_hold, chroma};
				pend        <= 1'b1;
			end else if (pend) begin
				pix_o       <= stash;
				pix_valid_o <= 1'b1;
			end
		end
	end

	// Vertical sync level brought into the system clock domain.
	logic        vs_s;
	logic        vs_s_d;
	logic [31:0] idle_cnt;
	pvi3d_sync2 #(
		.W(1)
	) u_vs_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (link.vsync),
		.q_o   (vs_s)
	);

	wire vs_toggle = vs_s ^ vs_s_d;
	wire stale = idle_cnt == TIMEOUT;

	// Watchdog: a vsync that stops toggling stops the sequencer and LEDs.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			vs_s_d    <= 1'b0;
			idle_cnt  <= TIMEOUT;
			seq_run_o <= 1'b0;
			led_en_o  <= 1'b0;
		end else begin
			vs_s_d <= vs_s;
			if (vs_toggle) begin
				idle_cnt <= 32'h0000_0000;
			end else if (!stale) begin
				idle_cnt <= idle_cnt + 32'h0000_0001;
			end
			seq_run_o <= vs_toggle | ~stale;
			led_en_o  <= vs_toggle | ~stale;
		end
	end
endmodule
`default_nettype wire

// ===== bench/pvi3d_link_sva.sv
// Checker for the video link and the capturing end beside it.
`timescale 1ns/100ps
`default_nettype none
module pvi3d_link_sva #(
	parameter int unsigned VS_TIMEOUT_CYC = pvi3d_pkg::VS_TIMEOUT_CYC
) (
	// Clocks and reset.
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        pclk,
	// Link wires.
	input wire logic        vsync,
	input wire logic        hsync,
	input wire logic        pixel_valid_in,
	input wire logic [23:0] pixel_bus,
	input wire logic        frame_update_mask,
	input wire logic        eye_select_in,
	// Capturing end configuration and outputs.
	input wire logic        vs_rise_i,
	input wire logic        hs_rise_i,
	input wire logic        mask_low_i,
	input wire logic [1:0]  fmt_i,
	input wire logic [23:0] pix_o,
	input wire logic        pix_valid_o,
	input wire logic        frame_start_o,
	input wire logic        frame_hold_o,
	input wire logic        eye_phase_o,
	input wire logic        line_start_o,
	input wire logic        seq_run_o,
	input wire logic        led_en_o
);
	logic [2:0]  vs_q;
	logic [31:0] idle;
	logic [4:0]  cfg_p1;
	logic [4:0]  cfg_p2;
	logic [4:0]  cfg_p3;

	// Configuration as the capturing end applies it: two sync flops, then its own register for mask polarity and format.
	always_ff @(posedge pclk or posedge rst_i) begin
		if (rst_i) begin
			cfg_p1 <= 5'h00;
			cfg_p2 <= 5'h00;
			cfg_p3 <= 5'h00;
		end else begin
			cfg_p1 <= {vs_rise_i, hs_rise_i, mask_low_i, fmt_i};
			cfg_p2 <= cfg_p1;
			cfg_p3 <= cfg_p2;
		end
	end

	// Sync edge choice, mask level after polarity and the format being received.
	wire logic vs_up   = cfg_p2[4];
	wire logic hs_up   = cfg_p2[3];
	wire logic mask_on = frame_update_mask ^ cfg_p3[2];
	wire logic is24    = cfg_p3[1:0] == pvi3d_pkg::PVI3D_FMT24;
	wire logic is16    = cfg_p3[1:0] == pvi3d_pkg::PVI3D_FMT16;

	// Cycles since vsync last moved, seen through two flops like the watchdog.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			vs_q <= 3'h0;
			idle <= 32'h0;
		end else begin
			vs_q <= {vs_q[1:0], vsync};
			idle <= (vs_q[2] != vs_q[1]) ? 32'h0 : idle + 32'h1;
		end
	end

	a_word_24: assert property (@(posedge pclk) disable iff (rst_i)
		pixel_valid_in && !mask_on && is24 |=> pix_valid_o && pix_o == $past(pixel_bus))
		else $error("24-bit word not passed on");
	a_no_word: assert property (@(posedge pclk) disable iff (rst_i)
		!pixel_valid_in && !is16 |=> !pix_valid_o) else $error("pixel without valid word");
	a_hold_on: assert property (@(posedge pclk) disable iff (rst_i)
		mask_on [*4] |-> frame_hold_o) else $error("mask active but no hold");
	a_hold_off: assert property (@(posedge pclk) disable iff (rst_i)
		!mask_on [*4] |-> !frame_hold_o) else $error("hold without mask");
	a_hold_blocks: assert property (@(posedge pclk) disable iff (rst_i)
		frame_hold_o |-> !pix_valid_o) else $error("pixel passed while held");
	a_frame_edge: assert property (@(posedge pclk) disable iff (rst_i)
		(vs_up ? $rose(vsync) : $fell(vsync)) |=> frame_start_o)
		else $error("vsync edge gave no frame start");
	a_line_edge: assert property (@(posedge pclk) disable iff (rst_i)
		(hs_up ? $rose(hsync) : $fell(hsync)) |=> line_start_o)
		else $error("hsync edge gave no line start");
	a_eye_sample: assert property (@(posedge pclk) disable iff (rst_i)
		frame_start_o |-> eye_phase_o == $past(eye_select_in)) else $error("eye phase wrong");
	a_mask_blank: assert property (@(posedge pclk) disable iff (rst_i)
		$changed(frame_update_mask) |-> !pixel_valid_in) else $error("mask moved in line");
	a_led_run: assert property (@(posedge clk_i) disable iff (rst_i)
		led_en_o == seq_run_o) else $error("leds disagree with sequencer");
	a_idle_stop: assert property (@(posedge clk_i) disable iff (rst_i)
		idle > VS_TIMEOUT_CYC + 8 |-> !seq_run_o) else $error("sequencer runs without vsync");
	a_run_live: assert property (@(posedge clk_i) disable iff (rst_i)
		vs_q[2] != vs_q[1] |=> seq_run_o) else $error("sequencer idle while vsync moves");

	// Main scenarios reached.
	c_hold: cover property (@(posedge pclk) disable iff (rst_i) $rose(frame_hold_o));
	c_eye: cover property (@(posedge pclk) disable iff (rst_i) $rose(eye_phase_o));
	c_stop: cover property (@(posedge clk_i) disable iff (rst_i) $fell(seq_run_o));
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Bench: source and capturing end joined over the link, driven over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", nm, (e), (g)); end end
module tb;
	localparam int unsigned TO = 4000;
	localparam logic [23:0] BASE = 24'h3a5c10;
	// Clock, reset and AXI4-Lite master side.
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	// Capturing end configuration and outputs.
	logic        vs_rise = 1'b1, hs_rise = 1'b1, mask_low = 1'b0;
	logic [1:0]  fmt = 2'h0;
	logic [23:0] pix, h = 24'h0;
	logic        pix_valid, frame_start, line_start, hold, eye, run, led;
	int          err_count = 0, tests_run = 0, frames = 0, cnt = 0, npix = 0, cyc = 0;

	pvi3d_link_if lnk ();
	pvi3d_src i_pvi3d_src (.clk_i(clk_i), .rst_i(rst_i), .link(lnk),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	pvi3d_dev #(.VS_TIMEOUT_CYC(TO)) i_pvi3d_dev (.clk_i(clk_i), .rst_i(rst_i), .link(lnk),
		.vs_rise_i(vs_rise), .hs_rise_i(hs_rise), .mask_low_i(mask_low), .fmt_i(fmt),
		.pix_o(pix), .pix_valid_o(pix_valid), .frame_start_o(frame_start),
		.line_start_o(line_start), .frame_hold_o(hold), .eye_phase_o(eye),
		.seq_run_o(run), .led_en_o(led));
	pvi3d_link_sva #(.VS_TIMEOUT_CYC(TO)) i_pvi3d_link_sva (.clk_i(clk_i), .rst_i(rst_i),
		.pclk(lnk.pclk), .vsync(lnk.vsync), .hsync(lnk.hsync),
		.pixel_valid_in(lnk.pixel_valid_in), .pixel_bus(lnk.pixel_bus),
		.frame_update_mask(lnk.frame_update_mask), .eye_select_in(lnk.eye_select_in),
		.vs_rise_i(vs_rise), .hs_rise_i(hs_rise), .mask_low_i(mask_low), .fmt_i(fmt),
		.pix_o(pix), .pix_valid_o(pix_valid), .frame_start_o(frame_start),
		.frame_hold_o(hold), .eye_phase_o(eye), .line_start_o(line_start),
		.seq_run_o(run), .led_en_o(led));

	// System clock; a hang counts as a mismatch.
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			err_count++;
			complete_run();
		end
	end

	// Pixel the source pattern should yield at column h in format f.
	function automatic logic [23:0] want(input logic [1:0] f, input logic [23:0] hh);
		logic [23:0] w, e;
		w = BASE + hh;
		e = BASE + {hh[23:1], 1'b0};
		case (f)
			pvi3d_pkg::PVI3D_FMT18: want = {w[17:12], w[17:16], w[11:6], w[11:10], w[5:0], w[5:4]};
			pvi3d_pkg::PVI3D_FMT16: want = {w[15:8], e[7:0], e[7:0] + 8'h1};
			default: want = w;
		endcase
	endfunction

	// Count pixels per frame and check each one at the settled pclk phase.
	always @(negedge lnk.pclk) begin
		if (line_start) h = 24'h0;
		if (frame_start) begin
			npix = cnt;
			cnt = 0;
			frames++;
		end
		if (pix_valid) begin
			`CHK("pix", want(fmt, h), pix)
			cnt++;
			h++;
		end
	end

	// AXI4-Lite write; ready and valid are judged before the edge that takes them.
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, b;
		logic [1:0] r;
		b = 1'b0;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b) begin
			@(negedge clk_i);
			ta = awvalid && awready;
			tw = wvalid && wready;
			b = bvalid;
			r = bresp;
			@(posedge clk_i);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (b) bready <= 1'b0;
		end
		`CHK("bresp", er, r)
	endtask

	// AXI4-Lite read.
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, got;
		got = 1'b0;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got) begin
			@(negedge clk_i);
			ta = arvalid && arready;
			got = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_i);
			if (ta) arvalid <= 1'b0;
			if (got) rready <= 1'b0;
		end
	endtask

	task automatic wait_frames(input int n);
		int t;
		t = frames + n;
		wait (frames >= t);
	endtask

	// Reconfigure both ends at a frame boundary, inside vertical blanking.
	task automatic cfg(input logic mk, d3, input logic [1:0] f, input logic vs, hs);
		wait_frames(1);
		wr(pvi3d_pkg::REG_CTRL, {26'h0, f, 1'b0, d3, mk, 1'b1}, pvi3d_pkg::RESP_OKAY);
		fmt <= f;
		vs_rise <= vs;
		hs_rise <= hs;
	endtask

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		rd(pvi3d_pkg::REG_CTRL, d, r);
		`CHK("ctrl", pvi3d_pkg::CTRL_RST, d)
		rd(pvi3d_pkg::REG_SIZE, d, r);
		`CHK("size", pvi3d_pkg::SIZE_RST, d)
		rd(4'h6, d, r);
		`CHK("unmapped rresp", pvi3d_pkg::RESP_SLVERR, r)
		wr(4'h6, 32'hffff_ffff, pvi3d_pkg::RESP_SLVERR);
		wr(pvi3d_pkg::REG_SIZE, 32'h0002_0004, pvi3d_pkg::RESP_OKAY);
		wr(pvi3d_pkg::REG_BASE, {8'h0, BASE}, pvi3d_pkg::RESP_OKAY);
		rd(pvi3d_pkg::REG_SIZE, d, r);
		`CHK("size", 32'h0002_0004, d)
		wr(pvi3d_pkg::REG_CTRL, 32'h1, pvi3d_pkg::RESP_OKAY);
	endtask

	// One format and sync edge choice: a whole frame of pixels, one frame out per frame in.
	task automatic t_fmt(input logic [1:0] f, input logic vs, hs);
		logic [31:0] s0, s1;
		logic [1:0]  r;
		cfg(1'b0, 1'b0, f, vs, hs);
		wait_frames(1);
		rd(pvi3d_pkg::REG_STATUS, s0, r);
		wait_frames(1);
		rd(pvi3d_pkg::REG_STATUS, s1, r);
		`CHK("pixels", 8, npix)
		`CHK("frames", 16'h1, 16'(s1[15:0] - s0[15:0]))
	endtask

	task automatic t_mask();
		cfg(1'b1, 1'b0, pvi3d_pkg::PVI3D_FMT24, 1'b1, 1'b1);
		wait_frames(2);
		`CHK("hold", 1'b1, hold)
		`CHK("masked pixels", 0, npix)
		cfg(1'b0, 1'b0, pvi3d_pkg::PVI3D_FMT24, 1'b1, 1'b1);
		mask_low <= 1'b1;
		wait_frames(2);
		`CHK("hold low", 1'b1, hold)
		`CHK("masked pixels", 0, npix)
		cfg(1'b0, 1'b0, pvi3d_pkg::PVI3D_FMT24, 1'b1, 1'b1);
		mask_low <= 1'b0;
		wait_frames(1);
		`CHK("hold", 1'b0, hold)
		`CHK("pixels", 8, npix)
	endtask

	task automatic t_eye();
		logic e;
		cfg(1'b0, 1'b1, pvi3d_pkg::PVI3D_FMT24, 1'b1, 1'b1);
		wait_frames(2);
		e = eye;
		wait_frames(1);
		`CHK("eye", ~e, eye)
		wait_frames(1);
		`CHK("eye", e, eye)
		`CHK("pixels", 8, npix)
	endtask

	task automatic t_watch();
		`CHK("run", 1'b1, run)
		wait_frames(1);
		wr(pvi3d_pkg::REG_CTRL, 32'h0, pvi3d_pkg::RESP_OKAY);
		repeat (TO + 200) @(posedge clk_i);
		@(negedge clk_i);
		`CHK("run", 1'b0, run)
		`CHK("led", 1'b0, led)
		wr(pvi3d_pkg::REG_CTRL, 32'h1, pvi3d_pkg::RESP_OKAY);
		wait_frames(1);
		`CHK("led", 1'b1, led)
	endtask

	task automatic complete_run();
		$display("Checks: %0d  mismatches: %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		@(posedge clk_i);
		rst_i <= 1'b1; // A real rising edge also resets the link side, whose clock stands still.
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_regs();
		t_fmt(pvi3d_pkg::PVI3D_FMT24, 1'b1, 1'b1);
		t_fmt(pvi3d_pkg::PVI3D_FMT18, 1'b0, 1'b0);
		t_fmt(pvi3d_pkg::PVI3D_FMT16, 1'b1, 1'b0);
		t_mask();
		t_eye();
		t_watch();
		complete_run();
	end
endmodule
`default_nettype wire
